// ### design/irq_bank.v
`timescale 1ns/10ps
`include "uart_shadow_regs.vh"

module irq_bank
(
  input wire clk,
  input wire resetn,
  input wire [`INT_WIDTH-1:0] event_set,
  input wire clear_write,
  input wire mask_write,
  input wire [`INT_WIDTH-1:0] wdata,
  output reg [`INT_WIDTH-1:0] status_reg,
  output reg [`INT_WIDTH-1:0] mask_reg,
  output wire irq
);

  // -------------------------------------------------------------
  // sticky status, write one to clear; a new event wins the clear
  // -------------------------------------------------------------
  wire [`INT_WIDTH-1:0] clear_bits;
  assign clear_bits = clear_write ? wdata : {`INT_WIDTH{1'b0}};

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_reg <= {`INT_WIDTH{1'b0}};
      mask_reg <= `INT_MASK_RESET;
    end
    else
    begin
      status_reg <= (status_reg & ~clear_bits) | event_set;
      if (mask_write)
      begin
        mask_reg <= wdata;
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule // irq_bank

// ### design/sir_break_pulser.v
`timescale 1ns/10ps
`include "uart_shadow_regs.vh"

module sir_break_pulser
(
  input wire clk,
  input wire resetn,
  input wire baud16_tick,
  input wire enable,
  output reg pulse_n_reg
);

  // -------------------------------------------------------------
  // one short low pulse per bit time while enabled
  // -------------------------------------------------------------
  reg [3:0] tick_count_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_count_reg <= 4'h0;
      pulse_n_reg <= 1'b1;
    end
    else if (!enable)
    begin
      tick_count_reg <= 4'h0;
      pulse_n_reg <= 1'b1;
    end
    else if (baud16_tick)
    begin
      if (tick_count_reg == `SIR_BIT_TICKS)
      begin
        tick_count_reg <= 4'h0;
      end
      else
      begin
        tick_count_reg <= tick_count_reg + 4'h1;
      end
      pulse_n_reg <= ~(tick_count_reg < `SIR_PULSE_TICKS);
    end
  end

endmodule // sir_break_pulser

// ### design/uart_shadow_control.v
`timescale 1ns/10ps
`include "uart_shadow_regs.vh"

module uart_shadow_control
(
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire tx_serial_data,
  input wire sir_data_n,
  input wire baud16_tick,
  input wire [`RX_LEVEL_WIDTH-1:0] rx_fifo_level,
  input wire tx_fifo_empty,
  input wire tx_fifo_full,
  output reg sout,
  output wire sir_out_n,
  output reg rx_break_loop,
  output reg tx_fifo_reset,
  output reg rx_fifo_reset,
  output reg rx_data_available,
  output reg dma_tx_req_n,
  output reg dma_rx_req_n,
  output wire irq
);

  // -------------------------------------------------------------
  // trigger level decode
  // -------------------------------------------------------------
  function [`RX_LEVEL_WIDTH-1:0] trigger_level;
    input [1:0] code;
    begin
      case (code)
        `TRIG_ONE_CHAR: trigger_level = 5'h01;
        `TRIG_QUARTER: trigger_level = `RX_FIFO_DEPTH >> 2;
        `TRIG_HALF: trigger_level = `RX_FIFO_DEPTH >> 1;
        `TRIG_TWO_LESS: trigger_level = `RX_FIFO_DEPTH - 5'h02;
        default: trigger_level = 5'h01;
      endcase
    end
  endfunction

  // 16-bit shadow view of a narrow field, upper bits zero
  function [15:0] shadow_word;
    input [1:0] field;
    input wide;
    begin
      shadow_word = wide ? {14'h0000, field} : {15'h0000, field[0]};
    end
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  reg [7:0] line_ctrl_reg;
  reg [7:0] line_ctrl_next;
  reg [7:0] modem_ctrl_reg;
  reg [7:0] modem_ctrl_next;
  reg [7:0] fifo_ctrl_reg;
  reg [7:0] fifo_ctrl_next;
  reg fifo_flush_reg;
  reg rx_trigger_hit_reg;
  reg rx_dma_armed_reg;
  reg tx_dma_armed_reg;

  wire break_on;
  wire loopback_on;
  wire sir_mode_on;
  wire fifo_enabled;
  wire dma_mode;
  wire [1:0] rx_trigger;
  wire rx_trigger_hit;
  wire rx_not_empty;
  wire [`INT_WIDTH-1:0] int_status;
  wire [`INT_WIDTH-1:0] int_mask;
  wire [`INT_WIDTH-1:0] int_events;
  wire pulser_n;

  assign break_on = line_ctrl_reg[`LINE_BREAK_BIT];
  assign loopback_on = modem_ctrl_reg[`MODEM_LOOPBACK_BIT];
  assign sir_mode_on = modem_ctrl_reg[`MODEM_SIR_MODE_BIT];
  assign fifo_enabled = fifo_ctrl_reg[`FIFO_CTRL_ENABLE_BIT];
  assign dma_mode = fifo_ctrl_reg[`FIFO_CTRL_DMA_MODE_BIT];
  assign rx_trigger = fifo_ctrl_reg[`FIFO_CTRL_RX_TRIGGER_MSB:`FIFO_CTRL_RX_TRIGGER_LSB];
  assign rx_not_empty = (rx_fifo_level != 5'h00);
  assign rx_trigger_hit = (rx_fifo_level >= trigger_level(rx_trigger));

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire setup_phase;
  wire write_access;
  wire addr_mapped;

  assign setup_phase = psel & ~penable;
  assign write_access = psel & penable & pwrite;
  // zero wait states: read data was captured in the setup cycle
  assign pready = 1'b1;

  assign addr_mapped = (paddr == `BREAK_SHADOW_ADDR) ||
                       (paddr == `DMA_MODE_SHADOW_ADDR) ||
                       (paddr == `FIFO_ENABLE_SHADOW_ADDR) ||
                       (paddr == `RECEIVE_TRIGGER_SHADOW_ADDR) ||
                       (paddr == `LINE_CONTROL_ADDR) ||
                       (paddr == `MODEM_CONTROL_ADDR) ||
                       (paddr == `FIFO_CONTROL_ADDR) ||
                       (paddr == `INT_STATUS_ADDR) ||
                       (paddr == `INT_MASK_ADDR) ||
                       (paddr == `BLOCK_STATUS_ADDR);

  // -------------------------------------------------------------
  // shared control state: shadows and full registers alias
  // -------------------------------------------------------------
  always @*
  begin
    line_ctrl_next = line_ctrl_reg;
    modem_ctrl_next = modem_ctrl_reg;
    fifo_ctrl_next = fifo_ctrl_reg;
    // fifo reset bits are self clearing
    fifo_ctrl_next[`FIFO_CTRL_RX_RESET_BIT] = 1'b0;
    fifo_ctrl_next[`FIFO_CTRL_TX_RESET_BIT] = 1'b0;
    if (write_access)
    begin
      case (paddr)
        `BREAK_SHADOW_ADDR: line_ctrl_next[`LINE_BREAK_BIT] = pwdata[0];
        `LINE_CONTROL_ADDR: line_ctrl_next = pwdata[7:0];
        `MODEM_CONTROL_ADDR: modem_ctrl_next = pwdata[7:0];
        `DMA_MODE_SHADOW_ADDR:
          fifo_ctrl_next[`FIFO_CTRL_DMA_MODE_BIT] = pwdata[0];
        `FIFO_ENABLE_SHADOW_ADDR:
          fifo_ctrl_next[`FIFO_CTRL_ENABLE_BIT] = pwdata[0];
        `RECEIVE_TRIGGER_SHADOW_ADDR:
          fifo_ctrl_next[`FIFO_CTRL_RX_TRIGGER_LSB +: 2] = pwdata[1:0];
        `FIFO_CONTROL_ADDR: fifo_ctrl_next = pwdata[7:0];
        default: line_ctrl_next = line_ctrl_reg;
      endcase
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_ctrl_reg <= `LINE_CTRL_RESET;
      modem_ctrl_reg <= `MODEM_CTRL_RESET;
      fifo_ctrl_reg <= `FIFO_CTRL_RESET;
    end
    else
    begin
      line_ctrl_reg <= line_ctrl_next;
      modem_ctrl_reg <= modem_ctrl_next;
      fifo_ctrl_reg <= fifo_ctrl_next;
    end
  end

  // -------------------------------------------------------------
  // fifo controller resets
  // -------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_flush_reg <= 1'b0;
      tx_fifo_reset <= 1'b0;
      rx_fifo_reset <= 1'b0;
    end
    else
    begin
      // enable going one to zero flushes both fifos
      fifo_flush_reg <= fifo_enabled & ~fifo_ctrl_next[`FIFO_CTRL_ENABLE_BIT];
      tx_fifo_reset <= (fifo_enabled & ~fifo_ctrl_next[`FIFO_CTRL_ENABLE_BIT]) |
                       fifo_ctrl_next[`FIFO_CTRL_TX_RESET_BIT];
      rx_fifo_reset <= (fifo_enabled & ~fifo_ctrl_next[`FIFO_CTRL_ENABLE_BIT]) |
                       fifo_ctrl_next[`FIFO_CTRL_RX_RESET_BIT];
    end
  end

  // -------------------------------------------------------------
  // break forcing and loopback
  // -------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sout <= 1'b1;
      rx_break_loop <= 1'b0;
    end
    else
    begin
      // line idles high while the transmitter is looped back
      if (loopback_on)
        sout <= 1'b1;
      else if (break_on)
        sout <= 1'b0;
      else
        sout <= tx_serial_data;
      rx_break_loop <= break_on & loopback_on;
    end
  end

  sir_break_pulser u_sir_break_pulser
  (
    .clk(clk),
    .resetn(resetn),
    .baud16_tick(baud16_tick),
    .enable(break_on & sir_mode_on & ~loopback_on),
    .pulse_n_reg(pulser_n)
  );

  reg sir_out_n_reg;
  assign sir_out_n = sir_out_n_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sir_out_n_reg <= 1'b1;
    end
    else if (break_on & sir_mode_on & ~loopback_on)
      sir_out_n_reg <= pulser_n;
    else if (loopback_on)
      sir_out_n_reg <= 1'b1;
    else
      sir_out_n_reg <= sir_data_n;
  end

  // -------------------------------------------------------------
  // receive trigger, data-available and dma requests
  // -------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_trigger_hit_reg <= 1'b0;
      rx_data_available <= 1'b0;
      rx_dma_armed_reg <= 1'b0;
      tx_dma_armed_reg <= 1'b0;
      dma_rx_req_n <= 1'b1;
      dma_tx_req_n <= 1'b1;
    end
    else
    begin
      rx_trigger_hit_reg <= rx_trigger_hit;
      // without fifos a single character is enough
      rx_data_available <= fifo_enabled ? rx_trigger_hit : rx_not_empty;
      // mode 1 receive: rise at trigger, hold until drained
      if (!rx_not_empty)
        rx_dma_armed_reg <= 1'b0;
      else if (rx_trigger_hit)
        rx_dma_armed_reg <= 1'b1;
      // mode 1 transmit: rise when empty, hold until full
      if (tx_fifo_full)
        tx_dma_armed_reg <= 1'b0;
      else if (tx_fifo_empty)
        tx_dma_armed_reg <= 1'b1;
      if (dma_mode & fifo_enabled)
      begin
        dma_rx_req_n <= ~(rx_dma_armed_reg | (rx_trigger_hit & rx_not_empty));
        dma_tx_req_n <= ~((tx_dma_armed_reg | tx_fifo_empty) & ~tx_fifo_full);
      end
      else
      begin
        dma_rx_req_n <= ~rx_not_empty;
        dma_tx_req_n <= ~tx_fifo_empty;
      end
    end
  end

  // -------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------
  reg break_on_d_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      break_on_d_reg <= 1'b0;
    end
    else
    begin
      break_on_d_reg <= break_on;
    end
  end

  assign int_events = {break_on & ~break_on_d_reg,
                       fifo_flush_reg,
                       rx_trigger_hit & ~rx_trigger_hit_reg & fifo_enabled};

  irq_bank u_irq_bank
  (
    .clk(clk),
    .resetn(resetn),
    .event_set(int_events),
    .clear_write(write_access && (paddr == `INT_STATUS_ADDR)),
    .mask_write(write_access && (paddr == `INT_MASK_ADDR)),
    .wdata(pwdata[`INT_WIDTH-1:0]),
    .status_reg(int_status),
    .mask_reg(int_mask),
    .irq(irq)
  );

  // -------------------------------------------------------------
  // read data, captured in the setup cycle
  // -------------------------------------------------------------
  reg [31:0] read_word;

  always @*
  begin
    read_word = 32'h00000000;
    case (paddr)
      `BREAK_SHADOW_ADDR: read_word = {16'h0000, shadow_word({1'b0, break_on}, 1'b0)};
      `DMA_MODE_SHADOW_ADDR: read_word = {16'h0000, shadow_word({1'b0, dma_mode}, 1'b0)};
      `FIFO_ENABLE_SHADOW_ADDR: read_word = {16'h0000, shadow_word({1'b0, fifo_enabled}, 1'b0)};
      `RECEIVE_TRIGGER_SHADOW_ADDR: read_word = {16'h0000, shadow_word(rx_trigger, 1'b1)};
      `LINE_CONTROL_ADDR: read_word = {24'h000000, line_ctrl_reg};
      `MODEM_CONTROL_ADDR: read_word = {24'h000000, modem_ctrl_reg};
      `FIFO_CONTROL_ADDR: read_word = {24'h000000, fifo_ctrl_reg};
      `INT_STATUS_ADDR: read_word = {29'h00000000, int_status};
      `INT_MASK_ADDR: read_word = {29'h00000000, int_mask};
      `BLOCK_STATUS_ADDR: read_word = {22'h000000, ~dma_tx_req_n, ~dma_rx_req_n,
                                       rx_data_available, rx_trigger_hit_reg,
                                       rx_break_loop, rx_fifo_level};
      default: read_word = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h00000000 : read_word;
      pslverr <= ~addr_mapped;
    end
  end

endmodule // uart_shadow_control

// ### design/uart_shadow_regs.vh
`ifndef UART_SHADOW_REGS_VH
`define UART_SHADOW_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define BREAK_SHADOW_ADDR 32'h50001090
`define DMA_MODE_SHADOW_ADDR 32'h50001094
`define FIFO_ENABLE_SHADOW_ADDR 32'h50001098
`define RECEIVE_TRIGGER_SHADOW_ADDR 32'h5000109C
`define LINE_CONTROL_ADDR 32'h500010C0
`define MODEM_CONTROL_ADDR 32'h500010C4
`define FIFO_CONTROL_ADDR 32'h500010C8
`define INT_STATUS_ADDR 32'h500010CC
`define INT_MASK_ADDR 32'h500010D0
`define BLOCK_STATUS_ADDR 32'h500010D4

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LINE_BREAK_BIT 6
`define MODEM_LOOPBACK_BIT 4
`define MODEM_SIR_MODE_BIT 6
`define FIFO_CTRL_ENABLE_BIT 0
`define FIFO_CTRL_RX_RESET_BIT 1
`define FIFO_CTRL_TX_RESET_BIT 2
`define FIFO_CTRL_DMA_MODE_BIT 3
`define FIFO_CTRL_RX_TRIGGER_LSB 6
`define FIFO_CTRL_RX_TRIGGER_MSB 7
`define INT_RX_TRIGGER_BIT 0
`define INT_FIFO_FLUSH_BIT 1
`define INT_BREAK_BIT 2
`define INT_WIDTH 3

// ---------------------------------------------------------------
// reset values and levels
// ---------------------------------------------------------------
`define LINE_CTRL_RESET 8'h00
`define MODEM_CTRL_RESET 8'h00
`define FIFO_CTRL_RESET 8'h00
`define INT_MASK_RESET 3'h0
`define RX_FIFO_DEPTH 5'h10
`define RX_LEVEL_WIDTH 5
`define TRIG_ONE_CHAR 2'h0
`define TRIG_QUARTER 2'h1
`define TRIG_HALF 2'h2
`define TRIG_TWO_LESS 2'h3

// ---------------------------------------------------------------
// timing counts (infrared pulse, in 16x baud ticks)
// ---------------------------------------------------------------
`define SIR_PULSE_TICKS 4'h3
`define SIR_BIT_TICKS 4'hF

`endif

// ### verif/uart_far_side.sv
`timescale 1ns/10ps

module uart_far_side
(
  input wire clk,
  input wire resetn,
  input wire [4:0] rx_target,
  input wire [4:0] tx_target,
  input wire rx_fifo_reset,
  input wire tx_fifo_reset,
  output reg [4:0] rx_fifo_level,
  output wire tx_fifo_empty,
  output wire tx_fifo_full,
  output wire baud16_tick,
  output wire tx_serial_data,
  output wire sir_data_n
);
  reg [1:0] div;
  reg [4:0] tx_cnt;

  // fill levels move one entry a cycle toward the target; a reset empties them
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div <= 2'h0;
      rx_fifo_level <= 5'h00;
      tx_cnt <= 5'h00;
    end
    else
    begin
      div <= div + 2'h1;
      if (rx_fifo_reset)
        rx_fifo_level <= 5'h00;
      else if (rx_fifo_level != rx_target)
        rx_fifo_level <= rx_fifo_level + ((rx_fifo_level < rx_target) ? 5'h01 : 5'h1F);
      if (tx_fifo_reset)
        tx_cnt <= 5'h00;
      else if (tx_cnt != tx_target)
        tx_cnt <= tx_cnt + ((tx_cnt < tx_target) ? 5'h01 : 5'h1F);
    end
  end

  assign tx_fifo_empty = tx_cnt == 5'h00;
  assign tx_fifo_full = tx_cnt == 5'h10;
  assign baud16_tick = div == 2'h3;
  assign tx_serial_data = div[0];
  assign sir_data_n = ~div[1];
endmodule // uart_far_side

// ### verif/uart_shadow_control_checker.sv
`timescale 1ns/10ps
`include "uart_shadow_regs.vh"

module uart_shadow_control_checker
(
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire [`RX_LEVEL_WIDTH-1:0] rx_fifo_level,
  input wire tx_fifo_empty,
  input wire sout,
  input wire sir_out_n,
  input wire rx_break_loop,
  input wire tx_fifo_reset,
  input wire rx_fifo_reset,
  input wire rx_data_available,
  input wire dma_tx_req_n,
  input wire dma_rx_req_n
);
  // ---------------------------------------------------------------
  // mirror of the control state seen through bus writes
  // ---------------------------------------------------------------
  reg brk, lb, sir, fen, dma;
  reg [1:0] trig;
  reg [4:0] thr;
  wire wr = psel && penable && pwrite && pready;
  wire hit = rx_fifo_level >= (fen ? thr : 5'h01);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {brk, lb, sir, fen, dma} <= 5'h00;
      trig <= 2'h0;
    end
    else if (wr)
    begin
      case (paddr)
        `BREAK_SHADOW_ADDR: brk <= pwdata[0];
        `LINE_CONTROL_ADDR: brk <= pwdata[6];
        `MODEM_CONTROL_ADDR: {sir, lb} <= {pwdata[6], pwdata[4]};
        `DMA_MODE_SHADOW_ADDR: dma <= pwdata[0];
        `FIFO_ENABLE_SHADOW_ADDR: fen <= pwdata[0];
        `RECEIVE_TRIGGER_SHADOW_ADDR: trig <= pwdata[1:0];
        `FIFO_CONTROL_ADDR: {trig, dma, fen} <= {pwdata[7:6], pwdata[3], pwdata[0]};
        default: ;
      endcase
    end
  end

  always @*
  begin
    case (trig)
      2'h0: thr = 5'h01;
      2'h1: thr = 5'h04;
      2'h2: thr = 5'h08;
      default: thr = 5'h0E;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence rd_break;
    psel && penable && !pwrite && paddr == `BREAK_SHADOW_ADDR;
  endsequence
  sequence spacing;
    brk && !lb;
  endsequence

  chk_break_readback: assert property (rd_break |-> prdata == {31'h0, brk})
    else $error("break shadow readback wrong");
  chk_break_spacing: assert property (spacing |=> !sout)
    else $error("serial line not spacing during break");
  chk_break_loop: assert property (brk && lb |=> rx_break_loop && sout)
    else $error("break not looped back");
  chk_sir_pulse: assert property ($rose(brk && sir && !lb) |-> ##[1:300] !sir_out_n)
    else $error("no infrared break pulse");
  chk_fifo_flush: assert property ($fell(fen) |-> rx_fifo_reset && tx_fifo_reset)
    else $error("fifos not reset on disable");
  chk_avail_hit: assert property (hit |=> rx_data_available)
    else $error("data available missing at trigger");
  chk_avail_low: assert property (!hit |=> !rx_data_available)
    else $error("data available below trigger");
  chk_rx_dma_one: assert property (dma && fen && hit |=> !dma_rx_req_n)
    else $error("receive request missing at trigger");
  chk_rx_dma_zero: assert property (!(dma && fen) && rx_fifo_level != 5'h00 |=> !dma_rx_req_n)
    else $error("receive request missing in mode zero");
  chk_tx_dma_empty: assert property (tx_fifo_empty |=> !dma_tx_req_n)
    else $error("transmit request missing when empty");
endmodule // uart_shadow_control_checker

bind uart_shadow_control uart_shadow_control_checker chk_u (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .rx_fifo_level(rx_fifo_level),
  .tx_fifo_empty(tx_fifo_empty), .sout(sout), .sir_out_n(sir_out_n),
  .rx_break_loop(rx_break_loop), .tx_fifo_reset(tx_fifo_reset), .rx_fifo_reset(rx_fifo_reset),
  .rx_data_available(rx_data_available), .dma_tx_req_n(dma_tx_req_n),
  .dma_rx_req_n(dma_rx_req_n));

// ### verif/uart_shadow_control_test.sv
`timescale 1ns/10ps
`include "uart_shadow_regs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module uart_shadow_control_test;
  reg clk, resetn, psel, penable, pwrite;
  reg [31:0] paddr, pwdata;
  reg [4:0] rx_target, tx_target, thr;
  wire [31:0] prdata;
  wire [4:0] rx_fifo_level;
  wire pready, pslverr, tx_serial_data, sir_data_n, baud16_tick, tx_fifo_empty, tx_fifo_full;
  wire sout, sir_out_n, rx_break_loop, tx_fifo_reset, rx_fifo_reset, rx_data_available;
  wire dma_tx_req_n, dma_rx_req_n, irq;
  integer num_errors = 0, n_checks = 0, i, k, wd;
  reg [32:0] expq[$];
  reg [32:0] e;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  uart_shadow_control dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_serial_data(tx_serial_data), .sir_data_n(sir_data_n),
    .baud16_tick(baud16_tick), .rx_fifo_level(rx_fifo_level), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_full(tx_fifo_full), .sout(sout), .sir_out_n(sir_out_n),
    .rx_break_loop(rx_break_loop), .tx_fifo_reset(tx_fifo_reset), .rx_fifo_reset(rx_fifo_reset),
    .rx_data_available(rx_data_available), .dma_tx_req_n(dma_tx_req_n),
    .dma_rx_req_n(dma_rx_req_n), .irq(irq));

  uart_far_side far_u (.clk(clk), .resetn(resetn), .rx_target(rx_target), .tx_target(tx_target),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .rx_fifo_level(rx_fifo_level),
    .tx_fifo_empty(tx_fifo_empty), .tx_fifo_full(tx_fifo_full), .baud16_tick(baud16_tick),
    .tx_serial_data(tx_serial_data), .sir_data_n(sir_data_n));

  task finish_test;
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one bus transfer; a read notes {pslverr, prdata} expected at completion
  task apb(input reg wr, input [31:0] a, input [31:0] d, input [32:0] x);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      expq.push_back(x);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready)
    begin
      e = expq.pop_front();
      `CHK("read", e, {pslverr, prdata})
    end
  end

  initial
  begin
    #300000;
    num_errors++;
    finish_test;
  end

  initial
  begin
    {resetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 64'h0;
    {rx_target, tx_target} = 10'h000;
    wd = $urandom(32'h8682);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // ---------------------------------------------------------------
    // reset values, then random writes with reserved bits set
    // ---------------------------------------------------------------
    for (i = 0; i < 4; i++)
      apb(1'b0, `BREAK_SHADOW_ADDR + 32'(4 * i), 32'h0, 33'h0);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, `BREAK_SHADOW_ADDR + 32'(4 * i), $urandom | 32'h3, 33'h0);
      apb(1'b0, `BREAK_SHADOW_ADDR + 32'(4 * i), 32'h0, (i == 3) ? 33'h3 : 33'h1);
    end
    apb(1'b0, `FIFO_CONTROL_ADDR, 32'h0, 33'h0C9);
    apb(1'b1, `LINE_CONTROL_ADDR, 32'h0, 33'h0);
    apb(1'b0, `BREAK_SHADOW_ADDR, 32'h0, 33'h0);
    // ---------------------------------------------------------------
    // break: spacing, loopback, infrared pulsing, interrupt
    // ---------------------------------------------------------------
    apb(1'b1, `LINE_CONTROL_ADDR, 32'h40, 33'h0);
    repeat (2) @(posedge clk);
    `CHK("sout", 1'b0, sout)
    apb(1'b1, `MODEM_CONTROL_ADDR, 32'h10, 33'h0);
    repeat (2) @(posedge clk);
    `CHK("sout", 1'b1, sout)
    `CHK("loop", 1'b1, rx_break_loop)
    apb(1'b1, `MODEM_CONTROL_ADDR, 32'h40, 33'h0);
    k = 0;
    while (sir_out_n !== 1'b0 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("sir", 1'b1, k < 300)
    apb(1'b0, `INT_STATUS_ADDR, 32'h0, 33'h4);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `INT_MASK_ADDR, 32'h7, 33'h0);
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, `INT_STATUS_ADDR, 32'h4, 33'h0);
    @(posedge clk);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `BREAK_SHADOW_ADDR, 32'h0, 33'h0);
    apb(1'b0, `LINE_CONTROL_ADDR, 32'h0, 33'h0);
    apb(1'b1, `MODEM_CONTROL_ADDR, 32'h0, 33'h0);
    // ---------------------------------------------------------------
    // disabling the fifos flushes them
    // ---------------------------------------------------------------
    apb(1'b1, `FIFO_ENABLE_SHADOW_ADDR, 32'h0, 33'h0);
    apb(1'b0, `INT_STATUS_ADDR, 32'h0, 33'h2);
    // ---------------------------------------------------------------
    // every trigger code, alternating dma modes
    // ---------------------------------------------------------------
    for (k = 0; k < 4; k++)
    begin
      thr = (k == 0) ? 5'h01 : (k == 1) ? 5'h04 : (k == 2) ? 5'h08 : 5'h0E;
      apb(1'b1, `FIFO_CONTROL_ADDR, {24'h0, 2'(k), 2'h0, 1'(k), 3'h1}, 33'h0);
      rx_target <= thr - 5'h01;
      tx_target <= 5'h08;
      repeat (20) @(posedge clk);
      `CHK("avail", 1'b0, rx_data_available)
      `CHK("rx req", (k % 2 == 1) || (thr == 5'h01), dma_rx_req_n)
      `CHK("tx req", k % 2 == 0, dma_tx_req_n)
      rx_target <= thr;
      repeat (20) @(posedge clk);
      `CHK("avail", 1'b1, rx_data_available)
      `CHK("rx req", 1'b0, dma_rx_req_n)
      apb(1'b0, `BLOCK_STATUS_ADDR, 32'h0, 33'((k % 2) * 512 + 448 + thr));
      apb(1'b0, `RECEIVE_TRIGGER_SHADOW_ADDR, 32'h0, 33'(k));
      apb(1'b0, `DMA_MODE_SHADOW_ADDR, 32'h0, 33'(k % 2));
      rx_target <= 5'h00;
      tx_target <= 5'h00;
      repeat (20) @(posedge clk);
    end
    apb(1'b0, 32'h500010A0, 32'h0, 33'h100000000);
    repeat (2) @(posedge clk);
    finish_test;
  end
endmodule // uart_shadow_control_test
